// File: pkg/cc_pkg.sv
// constants and types for the configurable direct-mapped cache
// ----------------------------------------------------------------
// Functional notes
// - instruction-only, data-only or split halves organization
// - organization set by privileged configuration register
// - direct mapped, fixed lines of sixteen bytes
// - tag array per line, data as 32-bit words
// - read hit answers data in one cycle
// - read miss fetches whole sixteen-byte line externally
// - first three words of incoming line held in line fill buffer, fourth goes straight to the array
// - data organizations use write-through
// - every operand write makes an external bus cycle
// ----------------------------------------------------------------
package cc_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int LINE_BYTES = 16;
	localparam int LINE_WORDS = 4;
	localparam int NUM_LINES = 512;
	localparam int IDX_W = 9;
	localparam int TAG_W = 20;
	// address field positions
	localparam int WORD_LSB = 2;
	localparam int IDX_LSB = 4;
	localparam int TAG_LSB = 12;
	// organization codes of cache_config_reg
	localparam logic [1:0] CFG_INSN = 2'h0;
	localparam logic [1:0] CFG_DATA = 2'h1;
	localparam logic [1:0] CFG_SPLIT = 2'h2;
	localparam logic [1:0] CFG_RESET = 2'h0;
	localparam logic [1:0] BEAT_LAST = 2'h3;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FILL = 3'b010,
		ST_WRITE = 3'b100
	} cc_state_t;
endpackage : cc_pkg

// File: src/cc_cache.sv
// configurable direct-mapped write-through cache between core and bus
`timescale 1ns/1ns
`default_nettype none
module cc_cache (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// configuration write port
	input wire logic cfg_wr,
	input wire logic cfg_priv,
	input wire logic [1:0] cfg_mode,
	output logic [1:0] cache_config_reg,
	output logic cfg_err,
	// core local bus
	input wire logic core_req,
	input wire logic core_we,
	input wire logic core_ifetch,
	input wire logic [31:0] core_addr,
	input wire logic [31:0] core_wdata,
	output logic core_ready,
	output logic core_ack,
	output logic [31:0] core_rdata,
	// external bus
	output logic bus_req,
	output logic bus_we,
	output logic [31:0] bus_addr,
	output logic [31:0] bus_wdata,
	input wire logic bus_ack,
	input wire logic [31:0] bus_rdata
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [cc_pkg::TAG_W-1:0] tag_mem [cc_pkg::NUM_LINES];
	logic [cc_pkg::LINE_WORDS-1:0][31:0] dat_mem [cc_pkg::NUM_LINES];
	logic [cc_pkg::NUM_LINES-1:0] valid_q, valid_d;
	logic [31:0] lfb_q [3], lfb_d [3];
	cc_pkg::cc_state_t state_q, state_d;
	logic [1:0] cfg_q, cfg_d, beat_q, beat_d;
	logic err_q, err_d, ack_q, ack_d, breq_q, breq_d, bwe_q, bwe_d;
	logic [31:0] rdata_q, rdata_d, baddr_q, baddr_d, bwdata_q, bwdata_d;
	logic [cc_pkg::IDX_W-1:0] ridx_q, ridx_d, idx;
	logic [1:0] rword_q, rword_d;
	logic rcache_q, rcache_d;
	logic cacheable, hit, take, cfg_take, tag_we, wr_hit;
	logic [31:0] fill_word;

	// ----------------------------------------------------------------
	// lookup
	// ----------------------------------------------------------------
	// split mode puts instructions in the low half and data in the high
	always_comb begin
		cacheable = 1'b0;
		idx = core_addr[cc_pkg::IDX_LSB +: cc_pkg::IDX_W];
		case (cfg_q)
			cc_pkg::CFG_INSN: cacheable = core_ifetch;
			cc_pkg::CFG_DATA: cacheable = !core_ifetch;
			cc_pkg::CFG_SPLIT: begin
				cacheable = 1'b1;
				idx = {!core_ifetch, core_addr[cc_pkg::IDX_LSB +: cc_pkg::IDX_W-1]};
			end
			default: cacheable = 1'b0;
		endcase
	end
	// tag holds addr[31:12]; in full modes bit 12 is also in the index
	assign hit = cacheable && valid_q[idx]
		&& tag_mem[idx] == core_addr[31:cc_pkg::TAG_LSB];
	assign cfg_take = cfg_wr && cfg_priv && state_q == cc_pkg::ST_IDLE;
	assign take = core_req && state_q == cc_pkg::ST_IDLE && !cfg_take;
	assign fill_word = (rword_q == cc_pkg::BEAT_LAST) ? bus_rdata : lfb_q[rword_q];
	assign tag_we = state_q == cc_pkg::ST_FILL && bus_ack && beat_q == cc_pkg::BEAT_LAST
		&& rcache_q;
	// write-through: a hit updates the stored word, the bus always sees it
	assign wr_hit = take && core_we && hit;

	// ----------------------------------------------------------------
	// control next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cfg_d = cfg_q;
		err_d = 1'b0;
		ack_d = 1'b0;
		rdata_d = rdata_q;
		breq_d = breq_q;
		bwe_d = bwe_q;
		baddr_d = baddr_q;
		bwdata_d = bwdata_q;
		beat_d = beat_q;
		valid_d = valid_q;
		ridx_d = ridx_q;
		rword_d = rword_q;
		rcache_d = rcache_q;
		lfb_d = lfb_q;
		// only privileged writes reach the register, and only when idle
		if (cfg_wr && !cfg_take) begin
			err_d = 1'b1;
		end
		if (cfg_take) begin
			cfg_d = cfg_mode;
			if (cfg_mode != cfg_q) begin
				valid_d = '0; // lines would alias under a new layout
			end
		end
		case (state_q)
			cc_pkg::ST_IDLE: begin
				if (take) begin
					ridx_d = idx;
					rword_d = core_addr[cc_pkg::WORD_LSB +: 2];
					rcache_d = cacheable;
					if (core_we) begin
						state_d = cc_pkg::ST_WRITE;
						breq_d = 1'b1;
						bwe_d = 1'b1;
						baddr_d = core_addr;
						bwdata_d = core_wdata;
					end else if (hit) begin
						ack_d = 1'b1;
						rdata_d = dat_mem[idx][core_addr[cc_pkg::WORD_LSB +: 2]];
					end else begin
						state_d = cc_pkg::ST_FILL;
						breq_d = 1'b1;
						bwe_d = 1'b0;
						baddr_d = {core_addr[31:cc_pkg::IDX_LSB], 4'h0};
						beat_d = 2'h0;
					end
				end
			end
			cc_pkg::ST_FILL: begin
				if (bus_ack) begin
					beat_d = beat_q + 2'h1;
					if (beat_q != cc_pkg::BEAT_LAST) begin
						lfb_d[beat_q] = bus_rdata;
					end else begin
						// uncached reads still fetch a line but never install it
						if (rcache_q) begin
							valid_d[ridx_q] = 1'b1;
						end
						state_d = cc_pkg::ST_IDLE;
						breq_d = 1'b0;
						ack_d = 1'b1;
						rdata_d = fill_word;
					end
				end
			end
			cc_pkg::ST_WRITE: begin
				if (bus_ack) begin
					state_d = cc_pkg::ST_IDLE;
					breq_d = 1'b0;
					bwe_d = 1'b0;
					ack_d = 1'b1;
				end
			end
			default: begin
				state_d = cc_pkg::ST_IDLE;
				breq_d = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= cc_pkg::ST_IDLE;
			cfg_q <= cc_pkg::CFG_RESET;
			err_q <= 1'b0;
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
			breq_q <= 1'b0;
			bwe_q <= 1'b0;
			baddr_q <= 32'h0;
			bwdata_q <= 32'h0;
			beat_q <= 2'h0;
			valid_q <= '0;
			ridx_q <= '0;
			rword_q <= 2'h0;
			rcache_q <= 1'b0;
			lfb_q <= '{default: 32'h0};
		end else begin
			state_q <= state_d;
			cfg_q <= cfg_d;
			err_q <= err_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
			breq_q <= breq_d;
			bwe_q <= bwe_d;
			baddr_q <= baddr_d;
			bwdata_q <= bwdata_d;
			beat_q <= beat_d;
			valid_q <= valid_d;
			ridx_q <= ridx_d;
			rword_q <= rword_d;
			rcache_q <= rcache_d;
			lfb_q <= lfb_d;
		end
	end

	// arrays carry no reset; valid bits guard them
	always_ff @(posedge clk) begin
		if (tag_we) begin
			tag_mem[ridx_q] <= baddr_q[31:cc_pkg::TAG_LSB];
			dat_mem[ridx_q] <= {bus_rdata, lfb_q[2], lfb_q[1], lfb_q[0]};
		end
		if (wr_hit) begin
			dat_mem[idx][core_addr[cc_pkg::WORD_LSB +: 2]] <= core_wdata;
		end
	end

	assign cache_config_reg = cfg_q;
	assign cfg_err = err_q;
	assign core_ready = state_q[0];
	assign core_ack = ack_q;
	assign core_rdata = rdata_q;
	assign bus_req = breq_q;
	assign bus_we = bwe_q;
	assign bus_addr = baddr_q;
	assign bus_wdata = bwdata_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_hit_one_cycle: assert property (@(posedge clk) disable iff (srst)
		take && !core_we && hit |=> core_ack && !bus_req)
		else $error("read hit not answered in one cycle");
	a_miss_line_fetch: assert property (@(posedge clk) disable iff (srst)
		take && !core_we && !hit |=> bus_req && !bus_we && bus_addr[3:0] == 4'h0)
		else $error("read miss did not start an aligned line fetch");
	a_write_bus_cycle: assert property (@(posedge clk) disable iff (srst)
		take && core_we |=> bus_req && bus_we && bus_wdata == $past(core_wdata))
		else $error("operand write produced no bus cycle");
	a_write_ack_after: assert property (@(posedge clk) disable iff (srst)
		core_ack && $past(state_q) == cc_pkg::ST_WRITE |-> $past(bus_ack))
		else $error("write acknowledged before bus completed");
	a_install_last: assert property (@(posedge clk) disable iff (srst)
		$rose(valid_q[ridx_q]) && $past(state_q) == cc_pkg::ST_FILL
		|-> $past(beat_q) == cc_pkg::BEAT_LAST && $past(bus_ack))
		else $error("line installed before fourth word");
	a_reset_invalid: assert property (@(posedge clk)
		$past(srst) |-> valid_q == '0 && !core_ack)
		else $error("valid bits not cleared by reset");
	a_cfg_privileged: assert property (@(posedge clk) disable iff (srst)
		cfg_wr && !cfg_priv |=> cfg_err && $stable(cache_config_reg))
		else $error("unprivileged configuration write took effect");
	a_split_halves: assert property (@(posedge clk) disable iff (srst)
		take && cache_config_reg == cc_pkg::CFG_SPLIT |-> idx[8] == !core_ifetch)
		else $error("split mode used the wrong half");
	a_fill_buffer: assert property (@(posedge clk) disable iff (srst)
		state_q == cc_pkg::ST_FILL && bus_ack && beat_q == 2'h0 |=> lfb_q[0] == $past(bus_rdata))
		else $error("first fill word not held in the line buffer");
endmodule : cc_cache
`default_nettype wire

// File: tb/cc_bus_model.sv
// external bus memory model answering the cache's line fills and writes
`timescale 1ns/1ns
`default_nettype none
module cc_bus_model (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// bus from the cache
	input wire logic bus_req,
	input wire logic bus_we,
	input wire logic [31:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	output logic bus_ack,
	output logic [31:0] bus_rdata,
	// stall control and observation
	input wire logic slow,
	output logic [7:0] fills,
	output logic [7:0] writes,
	output logic [31:0] wr_addr,
	output logic [31:0] wr_data
);
	logic [1:0] wt;
	logic [2:0] beat;
	// one beat per ack; slow mode waits four cycles per beat
	always_ff @(posedge clk) begin
		if (srst) begin
			bus_ack <= 1'b0;
			bus_rdata <= 32'h0;
			wt <= 2'h0;
			beat <= 3'h0;
			fills <= 8'h0;
			writes <= 8'h0;
		end else begin
			bus_ack <= 1'b0;
			bus_rdata <= ~bus_rdata; // released data never repeats a beat
			wt <= wt + 2'h1;
			if (!bus_req) begin
				beat <= 3'h0;
				wt <= 2'h0;
			end else if (beat != (bus_we ? 3'h1 : 3'h4) && (!slow || wt == 2'h3)) begin
				bus_ack <= 1'b1;
				wt <= 2'h0;
				beat <= beat + 3'h1;
				bus_rdata <= {bus_addr[31:4], beat[1:0], 2'h0} ^ 32'ha5a50000;
				if (bus_we) begin
					writes <= writes + 8'h1;
					wr_addr <= bus_addr;
					wr_data <= bus_wdata;
				end else if (beat == 3'h3) begin
					fills <= fills + 8'h1;
				end
			end
		end
	end
endmodule : cc_bus_model
`default_nettype wire

// File: tb/test_configurable_direct_mapped_cache.sv
// self-checking bench for the configurable direct-mapped cache
`timescale 1ns/1ns
`default_nettype none
module test_configurable_direct_mapped_cache;
	logic clk = 1'b0, srst = 1'b1, cfg_wr = 1'b0, cfg_priv = 1'b0, slow = 1'b0;
	logic core_req = 1'b0, core_we = 1'b0, core_ifetch = 1'b0;
	logic [1:0] cfg_mode = 2'h0, cache_config_reg;
	logic [31:0] core_addr = 32'h0, core_wdata = 32'h0, core_rdata, bus_addr, bus_wdata;
	logic [31:0] bus_rdata, wr_addr, wr_data;
	logic cfg_err, core_ready, core_ack, bus_req, bus_we, bus_ack;
	logic [7:0] fills, writes, f0;
	int num_errors = 0, cmp_count = 0, n;
	cc_cache cc_cache_i (.clk, .srst, .cfg_wr, .cfg_priv, .cfg_mode, .cache_config_reg,
		.cfg_err, .core_req, .core_we, .core_ifetch, .core_addr, .core_wdata, .core_ready,
		.core_ack, .core_rdata, .bus_req, .bus_we, .bus_addr, .bus_wdata, .bus_ack, .bus_rdata);
	cc_bus_model cc_bus_model_i (.clk, .srst, .bus_req, .bus_we, .bus_addr, .bus_wdata,
		.bus_ack, .bus_rdata, .slow, .fills, .writes, .wr_addr, .wr_data);
	always #5 clk = ~clk;
	task automatic stop_test();
		$display("checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// one core access; n counts edges from take to the edge that shows ack
	task automatic acc(input logic we, input logic ifc, input logic [31:0] a, d);
		@(posedge clk);
		core_req <= 1'b1;
		core_we <= we;
		core_ifetch <= ifc;
		core_addr <= a;
		core_wdata <= d;
		@(posedge clk);
		core_req <= 1'b0;
		n = 1;
		// ack is a one-cycle pulse, so look just after the take edge first
		#1;
		while (core_ack !== 1'b1 && n < 60) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (core_ack !== 1'b1) begin
			chk("ack wait", 32'h1, 32'h0);
			stop_test();
		end else begin
			chk("core ready", 32'h1, {31'h0, core_ready});
		end
	endtask : acc
	task automatic rd(input logic ifc, input logic [31:0] a, input logic hit, input logic [31:0] e);
		f0 = fills;
		acc(1'b0, ifc, a, 32'h0);
		chk("read data", e, core_rdata);
		chk("line fills", {24'h0, f0 + {7'h0, !hit}}, {24'h0, fills});
		chk("one cycle hit", {31'h0, hit}, {31'h0, n == 1});
	endtask : rd
	task automatic wr(input logic [31:0] a, d);
		f0 = writes;
		acc(1'b1, 1'b0, a, d);
		chk("bus writes", {24'h0, f0 + 8'h1}, {24'h0, writes});
		chk("write addr", a, wr_addr);
		chk("write data", d, wr_data);
	endtask : wr
	task automatic cfgw(input logic p, input logic [1:0] m, e);
		@(posedge clk);
		cfg_wr <= 1'b1;
		cfg_priv <= p;
		cfg_mode <= m;
		@(posedge clk);
		cfg_wr <= 1'b0;
		#1;
		chk("organization", {30'h0, e}, {30'h0, cache_config_reg});
		chk("refusal", {31'h0, !p}, {31'h0, cfg_err});
	endtask : cfgw
	function automatic logic [31:0] pat(input logic [31:0] a);
		return a ^ 32'ha5a50000;
	endfunction : pat
	task automatic t_insn();
		chk("reset organization", {30'h0, cc_pkg::CFG_RESET}, {30'h0, cache_config_reg});
		rd(1'b1, 32'h2000, 1'b0, pat(32'h2000));
		for (int k = 1; k < 4; k++) rd(1'b1, 32'h2000 + k * 4, 1'b1, pat(32'h2000 + k * 4));
		rd(1'b1, 32'h6000, 1'b0, pat(32'h6000));
		rd(1'b1, 32'h2000, 1'b0, pat(32'h2000));
		rd(1'b0, 32'h1000, 1'b0, pat(32'h1000));
		rd(1'b0, 32'h1000, 1'b0, pat(32'h1000));
		$display("instruction organization done");
	endtask : t_insn
	task automatic t_modes();
		cfgw(1'b0, cc_pkg::CFG_DATA, cc_pkg::CFG_INSN);
		rd(1'b1, 32'h2000, 1'b1, pat(32'h2000));
		for (int i = 0; i < 2; i++) begin
			cfgw(1'b1, i ? cc_pkg::CFG_SPLIT : cc_pkg::CFG_DATA, i ? 2'h2 : 2'h1);
			rd(1'b0, 32'h1000, 1'b0, pat(32'h1000));
			rd(1'b0, 32'h1000, 1'b1, pat(32'h1000));
			rd(1'b1, 32'h2000, 1'b0, pat(32'h2000));
			rd(1'b1, 32'h2000, i[0], pat(32'h2000));
		end
		$display("organizations done");
	endtask : t_modes
	task automatic t_write();
		slow <= 1'b1;
		wr(32'h1004, 32'h12345678);
		rd(1'b0, 32'h1004, 1'b1, 32'h12345678);
		wr(32'h1800, 32'h0badf00d);
		rd(1'b0, 32'h1800, 1'b0, pat(32'h1800));
		// organization 3 caches nothing: reads still fetch a line, never hit
		cfgw(1'b1, 2'h3, 2'h3);
		rd(1'b0, 32'h1800, 1'b0, pat(32'h1800));
		rd(1'b0, 32'h1800, 1'b0, pat(32'h1800));
		slow <= 1'b0;
		$display("write-through done");
	endtask : t_write
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		t_insn();
		t_modes();
		t_write();
		stop_test();
	end
endmodule : test_configurable_direct_mapped_cache
`default_nettype wire
